//--- design/palette_dac_ctrl.sv
// indexed control and status registers of a triple palette dac, with the
// pixel-side mask, blank/sync override, test capture and clock dividers
// assumes processor strobes are one-cycle pulses synchronous to core_clk
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// [RULE1]: index 01h reads back captured 30-bit dac inputs, one colour per read.
// [RULE2]: index 02h is a 3-bit read/write test register for sync, blank, phase.
// [RULE3]: index 03h returns a fixed identification code; writes ignored.
// [RULE4]: index 04h mask is anded bitwise with red, green and blue pixels.
// [RULE5]: host loads the mask with all ones for normal operation.
// [RULE6]: index 05h is command_first, ten bits, top two reserved.
// [RULE7]: host writes zero to command_first bit 1 and bits 3 to 7.
// [RULE8]: command_first reads zero in bit 1 and bits 3 to 9.
// [RULE9]: calibrate_bit with mode_calibrate_bit starts load synchroniser calibration.
// [RULE10]: sync_out_enable_bit enables composite sync output; cleared and floating at reset.
// [RULE11]: index 06h is command_second, bits 8 and 9 read zero.
// [RULE12]: test_trigger_edge_bit picks rising or falling red bit 7 for capture.
// [RULE13]: phase_trigger_select_bit picks blank or sync as phase output source.
// [RULE14]: sync_encode_bit puts sync onto green output or ignores it.
// [RULE15]: pedestal_select_bit picks 0 or 7.5 ire blanking pedestal.
// [RULE16]: colour_mode_field bits 7 to 4 select true or pseudo colour mode.
// [RULE17]: index 07h is command_third, bits 8 and 9 read zero.
// [RULE18]: prog_clock_divide_field sets programmable clock divide from pixel clock.
// [RULE19]: blank_delay_field adds extra blank pipeline stages for deskew.
// [RULE20]: multiplex_mode_field sets multiplexing and load output divide ratio.
// [RULE21]: index 0bh returns the silicon revision, read only.
// [RULE22]: blank forces blank level; with sync and encoding, green drops to sync.
// [RULE23]: access is index write to address register, then data write.
// [RULE24]: reset clears command_first, sets command_second and command_third to ones.
// [RULE25]: unassigned indices read zero and ignore writes.
module palette_dac_ctrl #(
  parameter logic [7:0] IDENT_CODE = 8'h5a, // arbitrary neutral value
  parameter logic [7:0] REVISION_CODE = 8'h01 // arbitrary neutral value
) (
  input wire logic core_clk, // pixel clock
  input wire logic nrst, // async reset, active low
  input wire logic mpu_wr, // write strobe, one-cycle pulse
  input wire logic mpu_rd, // read strobe, one-cycle pulse
  input wire logic [1:0] mpu_sel, // c1,c0 register select
  input wire logic [9:0] mpu_din, // write data
  output logic [9:0] mpu_dout, // read data, registered
  input wire logic test_mode, // test/diagnostic mode
  input wire logic mode_calibrate_bit, // calibrate bit of mode register
  input wire logic [7:0] pix_red, // red pixel in, bit 7 is red_bit7_input
  input wire logic [7:0] pix_green, // green pixel in
  input wire logic [7:0] pix_blue, // blue pixel in
  input wire logic blank_n, // blank, active low
  input wire logic sync_n, // sync, active low
  output logic [9:0] dac_red, // red dac input, registered
  output logic [9:0] dac_green, // green dac input, registered
  output logic [9:0] dac_blue, // blue dac input, registered
  output logic dac_blank_level, // outputs at blank level
  output logic green_sync_level, // green output at sync level
  output logic pedestal_on, // 7.5 ire pedestal selected
  output logic [3:0] colour_mode, // colour mode field
  output logic [1:0] multiplex_mode, // pixel multiplex field
  output logic composite_sync_output, // composite sync, active low
  output logic composite_sync_oe_n, // low while sync pin is driven
  output logic phase_sync_output, // phase synchronisation output
  output logic calibrate_start, // calibration start, one-cycle pulse
  output logic programmable_clock_output, // divided pixel clock
  output logic load_output // load clock for pixel multiplexing
);

  logic [7:0] addr_r, addr_nxt;
  logic [7:0] mask_r, mask_nxt;
  logic [2:0] sbp_r, sbp_nxt;
  logic [9:0] cmd1_r, cmd1_nxt;
  logic [9:0] cmd2_r, cmd2_nxt;
  logic [9:0] cmd3_r, cmd3_nxt;
  logic [9:0] dout_r, dout_nxt;
  palette_dac_pkg::readback_t rb_r, rb_nxt;
  logic [9:0] ctrl_rdata;
  logic [9:0] rb_word;

  logic [7:0] pr_r, pr_nxt;
  logic [7:0] pg_r, pg_nxt;
  logic [7:0] pb_r, pb_nxt;
  logic sync_d_r, sync_d_nxt;
  logic [palette_dac_pkg::BLANK_TAPS-1:0] bsh_r, bsh_nxt;
  logic [9:0] dr_r, dr_nxt;
  logic [9:0] dg_r, dg_nxt;
  logic [9:0] db_r, db_nxt;
  logic bl_r, bl_nxt;
  logic gs_r, gs_nxt;
  logic [29:0] cap_r, cap_nxt;
  logic r7_prev_r, r7_prev_nxt;
  logic mcal_prev_r, mcal_prev_nxt;
  logic cal_r, cal_nxt;
  logic csync_r, csync_nxt;
  logic phase_r, phase_nxt;

  logic blank_eff;
  logic sync_eff;
  logic blank_dly;
  logic capture;
  logic [3:0] bdly;

  assign bdly = cmd3_r[palette_dac_pkg::BDLY_LSB +: 4];

  // the readback pointer walks red, green, blue so a 30-bit word fits a 10-bit port
  always_comb begin
    unique case (rb_r)
      palette_dac_pkg::RB_RED: rb_word = cap_r[29:20]; // [RULE1]
      palette_dac_pkg::RB_GREEN: rb_word = cap_r[19:10];
      palette_dac_pkg::RB_BLUE: rb_word = cap_r[9:0];
      default: rb_word = 10'h000;
    endcase
  end

  always_comb begin
    case (addr_r)
      palette_dac_pkg::IDX_TEST_READBACK: ctrl_rdata = rb_word; // [RULE1]
      palette_dac_pkg::IDX_SBP_TEST: ctrl_rdata = {7'h00, sbp_r}; // [RULE2]
      palette_dac_pkg::IDX_IDENT: ctrl_rdata = {2'h0, IDENT_CODE}; // [RULE3]
      palette_dac_pkg::IDX_MASK: ctrl_rdata = {2'h0, mask_r}; // [RULE4]
      palette_dac_pkg::IDX_CMD1: ctrl_rdata = cmd1_r & palette_dac_pkg::CMD1_KEEP; // [RULE6] [RULE8]
      palette_dac_pkg::IDX_CMD2: ctrl_rdata = cmd2_r & palette_dac_pkg::CMD23_KEEP; // [RULE11]
      palette_dac_pkg::IDX_CMD3: ctrl_rdata = cmd3_r & palette_dac_pkg::CMD23_KEEP; // [RULE17]
      palette_dac_pkg::IDX_REVISION: ctrl_rdata = {2'h0, REVISION_CODE}; // [RULE21]
      default: ctrl_rdata = 10'h000; // [RULE25]
    endcase
  end

  always_comb begin
    addr_nxt = addr_r;
    mask_nxt = mask_r;
    sbp_nxt = sbp_r;
    cmd1_nxt = cmd1_r;
    cmd2_nxt = cmd2_r;
    cmd3_nxt = cmd3_r;
    dout_nxt = dout_r;
    rb_nxt = rb_r;
    if (mpu_wr && mpu_sel == palette_dac_pkg::SEL_ADDR) begin
      addr_nxt = mpu_din[7:0]; // [RULE23]
      rb_nxt = palette_dac_pkg::RB_RED;
    end else if (mpu_wr && mpu_sel == palette_dac_pkg::SEL_CTRL) begin
      case (addr_r) // [RULE23]
        palette_dac_pkg::IDX_SBP_TEST: sbp_nxt = mpu_din[2:0]; // [RULE2]
        palette_dac_pkg::IDX_MASK: mask_nxt = mpu_din[7:0]; // [RULE4]
        palette_dac_pkg::IDX_CMD1: cmd1_nxt = mpu_din & palette_dac_pkg::CMD1_KEEP; // [RULE8]
        palette_dac_pkg::IDX_CMD2: cmd2_nxt = mpu_din & palette_dac_pkg::CMD23_KEEP; // [RULE11]
        palette_dac_pkg::IDX_CMD3: cmd3_nxt = mpu_din & palette_dac_pkg::CMD23_KEEP; // [RULE17]
        default: begin
          // read-only and unassigned indices drop the write
        end
      endcase
    end
    if (mpu_rd) begin
      if (mpu_sel == palette_dac_pkg::SEL_ADDR) begin
        dout_nxt = {2'h0, addr_r};
      end else if (mpu_sel == palette_dac_pkg::SEL_CTRL) begin
        dout_nxt = ctrl_rdata;
        if (addr_r == palette_dac_pkg::IDX_TEST_READBACK) begin
          unique case (rb_r)
            palette_dac_pkg::RB_RED: rb_nxt = palette_dac_pkg::RB_GREEN;
            palette_dac_pkg::RB_GREEN: rb_nxt = palette_dac_pkg::RB_BLUE;
            palette_dac_pkg::RB_BLUE: rb_nxt = palette_dac_pkg::RB_RED;
            default: rb_nxt = palette_dac_pkg::RB_RED;
          endcase
        end
      end else begin
        // mode register and palette are outside this block
        dout_nxt = 10'h000;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      addr_r <= palette_dac_pkg::ADDR_RST;
      mask_r <= palette_dac_pkg::MASK_RST;
      sbp_r <= palette_dac_pkg::SBP_RST;
      cmd1_r <= palette_dac_pkg::CMD1_RST; // [RULE24] [RULE10]
      cmd2_r <= palette_dac_pkg::CMD2_RST; // [RULE24]
      cmd3_r <= palette_dac_pkg::CMD3_RST; // [RULE24]
      dout_r <= 10'h000;
      rb_r <= palette_dac_pkg::RB_RED;
    end else begin
      addr_r <= addr_nxt;
      mask_r <= mask_nxt;
      sbp_r <= sbp_nxt;
      cmd1_r <= cmd1_nxt;
      cmd2_r <= cmd2_nxt;
      cmd3_r <= cmd3_nxt;
      dout_r <= dout_nxt;
      rb_r <= rb_nxt;
    end
  end

  // in test mode the processor owns sync and blank instead of the pins
  always_comb begin
    blank_eff = test_mode ? sbp_r[palette_dac_pkg::TST_BLANK] : ~blank_n; // [RULE2]
    sync_eff = test_mode ? sbp_r[palette_dac_pkg::TST_SYNC] : ~sync_n;
  end

  always_comb begin
    pr_nxt = pix_red & mask_r; // [RULE4]
    pg_nxt = pix_green & mask_r;
    pb_nxt = pix_blue & mask_r;
    sync_d_nxt = sync_eff;
    bsh_nxt = {bsh_r[palette_dac_pkg::BLANK_TAPS-2:0], blank_eff};
    // tap 0 lines blank up with the pixel stage; higher taps add deskew delay
    blank_dly = bsh_r[bdly]; // [RULE19]
    if (blank_dly) begin
      dr_nxt = 10'h000; // [RULE22]
      dg_nxt = 10'h000;
      db_nxt = 10'h000;
      bl_nxt = 1'b1;
      gs_nxt = sync_d_r & cmd2_r[palette_dac_pkg::SYNC_ENC_BIT]; // [RULE22] [RULE14]
    end else begin
      dr_nxt = {pr_r, 2'h0};
      dg_nxt = {pg_r, 2'h0};
      db_nxt = {pb_r, 2'h0};
      bl_nxt = 1'b0;
      gs_nxt = 1'b0;
    end
    // edge bit one captures on rising red bit 7, zero on falling
    r7_prev_nxt = pix_red[7];
    if (cmd2_r[palette_dac_pkg::TRIG_EDGE_BIT]) begin
      capture = test_mode && !r7_prev_r && pix_red[7]; // [RULE12]
    end else begin
      capture = test_mode && r7_prev_r && !pix_red[7]; // [RULE12]
    end
    cap_nxt = capture ? {dr_r, dg_r, db_r} : cap_r; // [RULE1]
    if (test_mode) begin
      phase_nxt = sbp_r[palette_dac_pkg::TST_PHASE]; // [RULE2]
    end else if (cmd2_r[palette_dac_pkg::PHASE_SEL_BIT]) begin
      phase_nxt = sync_d_r; // [RULE13]
    end else begin
      phase_nxt = blank_dly; // [RULE13]
    end
    csync_nxt = ~sync_d_r;
    mcal_prev_nxt = mode_calibrate_bit;
    // calibration fires on the mode bit's 0-to-1 step while armed here
    cal_nxt = cmd1_r[palette_dac_pkg::CAL_BIT] && mode_calibrate_bit && !mcal_prev_r; // [RULE9]
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pr_r <= 8'h00;
      pg_r <= 8'h00;
      pb_r <= 8'h00;
      sync_d_r <= 1'b0;
      bsh_r <= '0;
      dr_r <= 10'h000;
      dg_r <= 10'h000;
      db_r <= 10'h000;
      bl_r <= 1'b0;
      gs_r <= 1'b0;
      cap_r <= '0;
      r7_prev_r <= 1'b0;
      phase_r <= 1'b0;
      csync_r <= 1'b1;
      mcal_prev_r <= 1'b0;
      cal_r <= 1'b0;
    end else begin
      pr_r <= pr_nxt;
      pg_r <= pg_nxt;
      pb_r <= pb_nxt;
      sync_d_r <= sync_d_nxt;
      bsh_r <= bsh_nxt;
      dr_r <= dr_nxt;
      dg_r <= dg_nxt;
      db_r <= db_nxt;
      bl_r <= bl_nxt;
      gs_r <= gs_nxt;
      cap_r <= cap_nxt;
      r7_prev_r <= r7_prev_nxt;
      phase_r <= phase_nxt;
      csync_r <= csync_nxt;
      mcal_prev_r <= mcal_prev_nxt;
      cal_r <= cal_nxt;
    end
  end

  // calibration realigns the load divider, the only phase that matters to load_input
  clock_ratio_divider u_prog_div (
    .core_clk(core_clk),
    .nrst(nrst),
    .phase_clear(1'b0),
    .ratio_log2(palette_dac_pkg::PCLK_LOG2[cmd3_r[palette_dac_pkg::PCLK_LSB +: 2]]), // [RULE18]
    .clk_out(programmable_clock_output)
  );

  clock_ratio_divider u_load_div (
    .core_clk(core_clk),
    .nrst(nrst),
    .phase_clear(cal_r), // [RULE9]
    .ratio_log2(palette_dac_pkg::MUX_LOG2[cmd3_r[palette_dac_pkg::MUX_LSB +: 2]]), // [RULE20]
    .clk_out(load_output)
  );

  assign mpu_dout = dout_r;
  assign dac_red = dr_r;
  assign dac_green = dg_r;
  assign dac_blue = db_r;
  assign dac_blank_level = bl_r;
  assign green_sync_level = gs_r;
  assign pedestal_on = cmd2_r[palette_dac_pkg::PED_BIT]; // [RULE15]
  assign colour_mode = cmd2_r[palette_dac_pkg::COLOUR_LSB +: 4]; // [RULE16]
  assign multiplex_mode = cmd3_r[palette_dac_pkg::MUX_LSB +: 2]; // [RULE20]
  assign composite_sync_output = csync_r;
  assign composite_sync_oe_n = ~cmd1_r[palette_dac_pkg::SYNC_OE_BIT]; // [RULE10]
  assign phase_sync_output = phase_r;
  assign calibrate_start = cal_r;

endmodule
`default_nettype wire

//--- inc/palette_dac_pkg.sv
// constants shared by the palette dac control registers and the clock divider
// assumes every user refers to these by palette_dac_pkg::name
package palette_dac_pkg;

  // register indices held in the address register
  localparam logic [7:0] IDX_TEST_READBACK = 8'h01;
  localparam logic [7:0] IDX_SBP_TEST = 8'h02;
  localparam logic [7:0] IDX_IDENT = 8'h03;
  localparam logic [7:0] IDX_MASK = 8'h04;
  localparam logic [7:0] IDX_CMD1 = 8'h05;
  localparam logic [7:0] IDX_CMD2 = 8'h06;
  localparam logic [7:0] IDX_CMD3 = 8'h07;
  localparam logic [7:0] IDX_REVISION = 8'h0b;

  // processor port selects (c1,c0)
  localparam logic [1:0] SEL_ADDR = 2'h0;
  localparam logic [1:0] SEL_CTRL = 2'h2;

  // values after reset
  localparam logic [7:0] ADDR_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'hff;
  localparam logic [2:0] SBP_RST = 3'h0;
  localparam logic [9:0] CMD1_RST = 10'h000;
  localparam logic [9:0] CMD2_RST = 10'h0ff;
  localparam logic [9:0] CMD3_RST = 10'h0ff;

  // implemented bits; the rest store nothing and read zero
  localparam logic [9:0] CMD1_KEEP = 10'h005;
  localparam logic [9:0] CMD23_KEEP = 10'h0ff;

  // command_first fields
  localparam int CAL_BIT = 0;
  localparam int SYNC_OE_BIT = 2;
  // command_second fields
  localparam int TRIG_EDGE_BIT = 0;
  localparam int PHASE_SEL_BIT = 1;
  localparam int SYNC_ENC_BIT = 2;
  localparam int PED_BIT = 3;
  localparam int COLOUR_LSB = 4;
  // command_third fields
  localparam int PCLK_LSB = 0;
  localparam int BDLY_LSB = 2;
  localparam int MUX_LSB = 6;
  // sync_blank_phase_test fields
  localparam int TST_SYNC = 0;
  localparam int TST_BLANK = 1;
  localparam int TST_PHASE = 2;

  // blank deskew depth: one base stage plus up to 15 extra
  localparam int BLANK_TAPS = 16;
  localparam int DIV_CNT_W = 5;

  // log2 of divide ratios; the core clock cannot give a unit ratio, so 1:1 runs at /2
  localparam logic [2:0] PCLK_LOG2 [0:3] = '{3'h2, 3'h3, 3'h4, 3'h5};
  localparam logic [2:0] MUX_LOG2 [0:3] = '{3'h1, 3'h1, 3'h2, 3'h2};

  typedef enum logic [1:0] {
    RB_RED = 2'b00,
    RB_GREEN = 2'b01,
    RB_BLUE = 2'b10
  } readback_t;

endpackage

//--- design/clock_ratio_divider.sv
// power-of-two divider of core_clk with a phase clear
// assumes ratio_log2 lies between 1 and 5
`timescale 1ns/10ps
`default_nettype none
module clock_ratio_divider (
  input wire logic core_clk, // pixel clock
  input wire logic nrst, // async reset, active low
  input wire logic phase_clear, // restart count, one-cycle pulse
  input wire logic [2:0] ratio_log2, // divide by 2**ratio_log2
  output logic clk_out // divided clock, registered
);

  logic [palette_dac_pkg::DIV_CNT_W-1:0] cnt_r;
  logic [palette_dac_pkg::DIV_CNT_W-1:0] cnt_nxt;
  logic out_r;
  logic out_nxt;
  logic [2:0] tap;

  always_comb begin
    tap = ratio_log2 - 3'h1;
    if (phase_clear) begin
      cnt_nxt = '0;
    end else begin
      cnt_nxt = cnt_r + 5'h01;
    end
    out_nxt = cnt_nxt[tap];
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= '0;
      out_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      out_r <= out_nxt;
    end
  end

  assign clk_out = out_r;

endmodule
`default_nettype wire

//--- dv/palette_dac_ctrl_asserts.sv
// port-level checker for palette_dac_ctrl
// assumes one clock domain and the async active-low reset of the block
`timescale 1ns/10ps
`default_nettype none
module palette_dac_ctrl_chk (
  input wire logic core_clk, // pixel clock
  input wire logic nrst, // async reset, active low
  input wire logic mpu_rd, // read strobe
  input wire logic [9:0] mpu_dout, // read data
  input wire logic mode_calibrate_bit, // mode register calibrate
  input wire logic [9:0] dac_red, // red dac input
  input wire logic [9:0] dac_green, // green dac input
  input wire logic [9:0] dac_blue, // blue dac input
  input wire logic dac_blank_level, // blanked
  input wire logic green_sync_level, // green at sync level
  input wire logic pedestal_on, // pedestal select
  input wire logic [3:0] colour_mode, // colour mode field
  input wire logic [1:0] multiplex_mode, // multiplex field
  input wire logic composite_sync_oe_n, // sync pin enable, low drives
  input wire logic calibrate_start, // calibration pulse
  input wire logic load_output // load clock
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  a_reset_fields: assert property ($rose(nrst) |-> pedestal_on && colour_mode == 4'hf && multiplex_mode == 2'h3)
    else $error("command fields not at reset value");
  a_sync_pin_float: assert property ($rose(nrst) |-> composite_sync_oe_n)
    else $error("sync pin driven after reset");
  a_read_hold: assert property (!mpu_rd |=> $stable(mpu_dout))
    else $error("read data changed without a read");
  a_cal_pulse: assert property (calibrate_start |-> $past(mode_calibrate_bit) ##1 !calibrate_start)
    else $error("calibration pulse without cause or too long");
  a_sync_needs_blank: assert property (green_sync_level |-> dac_blank_level)
    else $error("sync level outside blanking");
  a_blank_zero_data: assert property (dac_blank_level |-> {dac_red, dac_green, dac_blue} == 30'h0)
    else $error("pixel data leaks through blanking");
  a_dac_low_bits: assert property (dac_red[1:0] == 2'h0 && dac_green[1:0] == 2'h0 && dac_blue[1:0] == 2'h0)
    else $error("dac low bits not zero");
  a_load_half_rate: assert property ((multiplex_mode < 2'h2 && !calibrate_start) [*3] |-> load_output != $past(load_output))
    else $error("load clock not at half rate");
endmodule
bind palette_dac_ctrl palette_dac_ctrl_chk chk (.core_clk, .nrst, .mpu_rd, .mpu_dout, .mode_calibrate_bit,
  .dac_red, .dac_green, .dac_blue, .dac_blank_level, .green_sync_level, .pedestal_on, .colour_mode,
  .multiplex_mode, .composite_sync_oe_n, .calibrate_start, .load_output);
`default_nettype wire

//--- dv/host_port_model.sv
// host processor model on the register port
// assumes requests start after reset release; strobes change at falling edges
`timescale 1ns/10ps
`default_nettype none
module host_port_model (
  input wire logic core_clk, // pixel clock
  output logic mpu_wr, // write strobe
  output logic mpu_rd, // read strobe
  output logic [1:0] mpu_sel, // register select
  output logic [9:0] mpu_din, // write data
  input wire logic [9:0] mpu_dout // read data
);
  initial begin
    mpu_wr = 1'b0;
    mpu_rd = 1'b0;
    mpu_sel = 2'h1;
    mpu_din = 10'h155;
  end
  // idle lines flip so a stale value never looks valid
  task automatic cycle(input logic wr, input logic [1:0] sel, input logic [9:0] din);
    @(negedge core_clk);
    mpu_wr = wr;
    mpu_rd = !wr;
    mpu_sel = sel;
    mpu_din = din;
    @(negedge core_clk);
    mpu_wr = 1'b0;
    mpu_rd = 1'b0;
    mpu_sel = ~sel;
    mpu_din = ~din;
  endtask
  task automatic wr_reg(input logic [7:0] idx, input logic [9:0] val);
    cycle(1'b1, palette_dac_pkg::SEL_ADDR, {2'h0, idx});
    cycle(1'b1, palette_dac_pkg::SEL_CTRL, val);
  endtask
  task automatic rd_data(output logic [9:0] val);
    cycle(1'b0, palette_dac_pkg::SEL_CTRL, 10'h000);
    val = mpu_dout;
  endtask
  task automatic rd_reg(input logic [7:0] idx, output logic [9:0] val);
    cycle(1'b1, palette_dac_pkg::SEL_ADDR, {2'h0, idx});
    rd_data(val);
  endtask
  task automatic wr_cmd1(input logic [9:0] val);
    wr_reg(palette_dac_pkg::IDX_CMD1, val & palette_dac_pkg::CMD1_KEEP);
  endtask
  task automatic normal_mask;
    wr_reg(palette_dac_pkg::IDX_MASK, 10'h0ff);
  endtask
endmodule
`default_nettype wire

//--- dv/palette_dac_ctrl_test.sv
// self-checking bench for palette_dac_ctrl
// assumes host_port_model and the bound checker are compiled first
`timescale 1ns/10ps
`default_nettype none
module palette_dac_ctrl_test;
  localparam logic [7:0] ID_P = 8'h3c; // arbitrary value
  localparam logic [7:0] REV_P = 8'h07; // arbitrary value
  logic core_clk, nrst, mpu_wr, mpu_rd, test_mode, mode_cal, blank_n, sync_n;
  logic [1:0] mpu_sel, mux;
  logic [9:0] mpu_din, mpu_dout, dac_red, dac_green, dac_blue;
  logic [7:0] pix_red, pix_green, pix_blue;
  logic blank_lvl, gsync, ped, sync_out, sync_oe_n, phase, cal, pclk_out, load_out;
  logic [3:0] colour;
  int n_errors = 0;
  int total_checks = 0;
  palette_dac_ctrl #(.IDENT_CODE(ID_P), .REVISION_CODE(REV_P)) uut (.core_clk(core_clk), .nrst(nrst),
    .mpu_wr(mpu_wr), .mpu_rd(mpu_rd), .mpu_sel(mpu_sel), .mpu_din(mpu_din), .mpu_dout(mpu_dout),
    .test_mode(test_mode), .mode_calibrate_bit(mode_cal), .pix_red(pix_red), .pix_green(pix_green),
    .pix_blue(pix_blue), .blank_n(blank_n), .sync_n(sync_n), .dac_red(dac_red), .dac_green(dac_green),
    .dac_blue(dac_blue), .dac_blank_level(blank_lvl), .green_sync_level(gsync), .pedestal_on(ped),
    .colour_mode(colour), .multiplex_mode(mux), .composite_sync_output(sync_out),
    .composite_sync_oe_n(sync_oe_n), .phase_sync_output(phase), .calibrate_start(cal),
    .programmable_clock_output(pclk_out), .load_output(load_out));
  host_port_model host (.core_clk(core_clk), .mpu_wr(mpu_wr), .mpu_rd(mpu_rd), .mpu_sel(mpu_sel),
    .mpu_din(mpu_din), .mpu_dout(mpu_dout));
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic finish_test;
    if (n_errors == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic t_reset_regs;
    logic [7:0] ri [5] = '{8'h05, 8'h06, 8'h07, 8'h04, 8'h02};
    logic [9:0] re [5] = '{10'h000, 10'h0ff, 10'h0ff, 10'h0ff, 10'h000};
    logic [9:0] v;
    for (int i = 0; i < 5; i++) begin
      host.rd_reg(ri[i], v);
      check($sformatf("reset_reg_%h", ri[i]), v, re[i]);
    end
    check("sync_oe_n", sync_oe_n, 1'b1);
  endtask
  task automatic t_fixed_regs;
    logic [7:0] un [6] = '{8'h00, 8'h08, 8'h09, 8'h0a, 8'h0c, 8'hff};
    logic [9:0] v;
    for (int i = 0; i < 6; i++) host.wr_reg(un[i], 10'h3ff);
    host.wr_reg(8'h03, 10'h3ff);
    host.wr_reg(8'h0b, 10'h3ff);
    host.rd_reg(8'h03, v);
    check("ident", v, {2'h0, ID_P});
    host.rd_reg(8'h0b, v);
    check("revision", v, {2'h0, REV_P});
    for (int i = 0; i < 6; i++) begin
      host.rd_reg(un[i], v);
      check($sformatf("unassigned_%h", un[i]), v, 10'h000);
    end
  endtask
  task automatic t_cmd_bits;
    logic [9:0] v;
    logic [9:0] c2 [2] = '{10'h0a5, 10'h35a};
    host.wr_reg(8'h05, 10'h3ff);
    host.rd_reg(8'h05, v);
    check("command_first", v, 10'h005);
    check("sync_oe_n", sync_oe_n, 1'b0);
    host.wr_cmd1(10'h000);
    for (int i = 0; i < 2; i++) begin
      host.wr_reg(8'h06, c2[i]);
      host.rd_reg(8'h06, v);
      check("command_second", v, {2'h0, c2[i][7:0]});
      check("pedestal", ped, c2[i][3]);
      check("colour_mode", colour, c2[i][7:4]);
    end
    host.wr_reg(8'h07, 10'h3c5);
    host.rd_reg(8'h07, v);
    check("command_third", v, 10'h0c5);
    check("multiplex_mode", mux, 2'h3);
    host.wr_reg(8'h02, 10'h3ff);
    host.rd_reg(8'h02, v);
    check("sbp_test", v, 10'h007);
    host.wr_reg(8'h02, 10'h3fa);
    host.rd_reg(8'h02, v);
    check("sbp_test", v, 10'h002);
  endtask
  task automatic t_mask;
    host.wr_reg(8'h04, 10'h00f);
    pix_red = 8'ha5;
    pix_green = 8'h3c;
    pix_blue = 8'hff;
    cyc(4);
    check("masked_rgb", {dac_red, dac_green, dac_blue}, {10'h014, 10'h030, 10'h03c});
    host.normal_mask();
    cyc(4);
    check("clear_rgb", {dac_red, dac_green, dac_blue}, {10'h294, 10'h0f0, 10'h3fc});
  endtask
  task automatic blank_lag(output int n);
    @(negedge core_clk);
    blank_n = 1'b0;
    sync_n = 1'b0;
    n = 0;
    while (blank_lvl !== 1'b1 && n < 40) begin
      @(negedge core_clk);
      n++;
    end
    cyc(2);
  endtask
  task automatic t_blank_sync;
    int n0, n1;
    host.wr_reg(8'h07, 10'h000);
    host.wr_reg(8'h06, 10'h004);
    blank_lag(n0);
    check("blanked_rgb", {dac_red, dac_green, dac_blue}, 30'h0);
    check("green_sync", gsync, 1'b1);
    check("sync_out", sync_out, 1'b0);
    sync_n = 1'b1;
    cyc(3);
    check("phase_from_blank", phase, 1'b1);
    check("sync_out", sync_out, 1'b1);
    blank_n = 1'b1;
    sync_n = 1'b1;
    host.wr_reg(8'h07, 10'h010);
    host.wr_reg(8'h06, 10'h002);
    cyc(20);
    blank_lag(n1);
    check("blank_lag", n1, n0 + 4);
    check("green_sync", gsync, 1'b0);
    check("phase_from_sync", phase, 1'b1);
    sync_n = 1'b1;
    cyc(3);
    check("phase_from_sync", phase, 1'b0);
    check("still_blank", blank_lvl, 1'b1);
    blank_n = 1'b1;
    sync_n = 1'b1;
  endtask
  task automatic t_dividers;
    int rp, rl;
    logic pp, lp;
    for (int p = 0; p < 4; p++) begin
      host.wr_reg(8'h07, {2'h0, (p < 2) ? 2'h0 : 2'h2, 4'h0, p[1:0]});
      cyc(40);
      rp = 0;
      rl = 0;
      pp = pclk_out;
      lp = load_out;
      repeat (96) begin
        @(negedge core_clk);
        rp += int'(pclk_out === 1'b1 && pp === 1'b0);
        rl += int'(load_out === 1'b1 && lp === 1'b0);
        pp = pclk_out;
        lp = load_out;
      end
      check("prog_clock_rises", rp, 96 / (4 << p));
      check("load_rises", rl, (p < 2) ? 48 : 24);
    end
  endtask
  task automatic t_calibrate;
    int n;
    for (int k = 1; k >= 0; k--) begin
      host.wr_cmd1(k[0] ? 10'h3ff : 10'h000);
      mode_cal = 1'b0;
      cyc(3);
      mode_cal = 1'b1;
      n = 0;
      repeat (8) begin
        @(negedge core_clk);
        n += int'(cal === 1'b1);
      end
      check("calibrate_pulses", n, k);
    end
    mode_cal = 1'b0;
  endtask
  // red bit 9 is left out: capture timing against the pixel pipe is not pinned down
  task automatic rb_check(input logic [9:0] g, input logic [9:0] b);
    logic [9:0] v;
    host.rd_reg(8'h01, v);
    check("readback_red", v & 10'h1fc, 10'h048);
    host.rd_data(v);
    check("readback_green", v, g);
    host.rd_data(v);
    check("readback_blue", v, b);
  endtask
  task automatic t_readback;
    test_mode = 1'b1;
    host.wr_reg(8'h02, 10'h005);
    host.wr_reg(8'h06, 10'h001);
    pix_red = 8'h12;
    pix_green = 8'h34;
    pix_blue = 8'h56;
    cyc(6);
    check("test_blank", blank_lvl, 1'b0);
    check("test_phase", phase, 1'b1);
    check("test_sync", sync_out, 1'b0);
    pix_red = 8'h92;
    cyc(6);
    rb_check(10'h0d0, 10'h158);
    pix_green = 8'h78;
    cyc(6);
    pix_red = 8'h12;
    cyc(6);
    rb_check(10'h0d0, 10'h158);
    host.wr_reg(8'h06, 10'h000);
    pix_red = 8'h92;
    cyc(6);
    rb_check(10'h0d0, 10'h158);
    pix_red = 8'h12;
    cyc(6);
    rb_check(10'h1e0, 10'h158);
    test_mode = 1'b0;
  endtask
  initial begin
    nrst = 1'b0;
    test_mode = 1'b0;
    mode_cal = 1'b0;
    blank_n = 1'b1;
    sync_n = 1'b1;
    pix_red = 8'h00;
    pix_green = 8'h00;
    pix_blue = 8'h00;
    repeat (20) @(negedge core_clk);
    nrst = 1'b1;
    t_reset_regs();
    t_fixed_regs();
    t_cmd_bits();
    t_mask();
    t_blank_sync();
    t_dividers();
    t_calibrate();
    t_readback();
    finish_test();
  end
  // the sequence needs under a thousand cycles; this is over twenty times that
  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    finish_test();
  end
endmodule
`default_nettype wire
